// ### design/iocd_device.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module iocd_device (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [11:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [11:0] reg_rdata,
    input wire logic device_access_strobe_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic [0:11] data_in,
    output logic [0:11] data_out,
    output logic data_oe,
    input wire logic interrupt_grant_n,
    input wire logic chain_grant_in_n,
    output logic chain_grant_out_n,
    output logic interrupt_request_line_o,
    output logic interrupt_request_line_oe,
    output logic skip_o,
    output logic skip_oe,
    output logic ctrl_line_zero_o,
    output logic ctrl_line_zero_oe,
    output logic ctrl_line_one_o,
    output logic ctrl_line_one_oe,
    input wire logic sense_in,
    output logic strobe_out,
    output logic enable_n
);
    import iocd_pkg::*;
    // the processor pins come in synchronous to core_clk, so each edge
    // below is a plain compare of this sample against the last one; the
    // price is one cycle of lag, which the processor's pulse widths cover

    // programming word and access tracking
    iocd_cfg_s cfg_r;
    iocd_phase_e phase_r, phase_nxt;
    logic [0:11] instr_r;       // instruction caught at strobe fall
    logic vec_r;                // this access is a vector access
    logic first_pend_r;         // grant low, no access seen yet
    // device flip flops
    logic flag_r, flag_nxt;
    logic fsamp_r;
    logic ie_r;
    logic isamp_r, isamp_nxt;
    logic strobe_r, strobe_nxt;
    // previous input levels for edge finding
    logic as_prev_r;
    logic wr_prev_r;
    logic rd_prev_r;
    logic gnt_prev_r;
    logic sense_prev_r;
    logic [11:0] reg_rdata_r;
    logic [0:11] data_out_r;

    // edges of the processor timing signals
    wire logic acc_fall = as_prev_r & ~device_access_strobe_n;
    wire logic acc_rise = ~as_prev_r & device_access_strobe_n;
    wire logic wr_fall = wr_prev_r & ~write_n;
    wire logic rd_fall = rd_prev_r & ~read_n;
    wire logic grant_fall = gnt_prev_r & ~interrupt_grant_n;

    // sense level translated to its programmed true sense
    wire logic sense_true = ~(sense_in ^ cfg_r.in_pol);
    wire logic sense_edge = sense_true & ~sense_prev_r & cfg_r.edge_mode;

    // decode of the word on the bus at strobe fall
    wire logic [5:0] in_addr = data_in[IOCD_ADDR_MSB:IOCD_ADDR_LSB];
    wire iocd_cmd_e in_cmd = iocd_cmd_e'(data_in[IOCD_CMD_MSB:IOCD_CMD_LSB]);
    // first_eff also covers a strobe fall in the very cycle the grant
    // fall is seen, before first_pend_r has had a chance to set
    wire logic first_eff = first_pend_r | grant_fall;
    // a non-skip first instruction under grant becomes a vector access
    wire logic vector_now = ~interrupt_grant_n & first_eff & (in_cmd != IOCD_CMD_SKIP);
    wire logic in_hit = (in_addr == cfg_r.dev_addr) & ~vector_now;

    // decode of the latched instruction during the access
    wire iocd_cmd_e cmd = iocd_cmd_e'(instr_r[IOCD_CMD_MSB:IOCD_CMD_LSB]);
    wire logic in_access = (phase_r == IOCD_PH_ACCESS);
    // vector accesses never act as addressed commands
    wire logic addr_hit = in_access & ~vec_r &
        (instr_r[IOCD_ADDR_MSB:IOCD_ADDR_LSB] == cfg_r.dev_addr);
    wire logic wr_act = in_access & ~write_n;
    wire logic rd_act = in_access & ~read_n;
    wire logic is_xfer = (cmd == IOCD_CMD_XFER) | (cmd == IOCD_CMD_XFER_CLR);
    wire logic is_skip = addr_hit & (cmd == IOCD_CMD_SKIP);
    wire logic is_setf = addr_hit & (cmd == IOCD_CMD_SET_FLAG);
    // only the first device in the chain with a sample answers
    wire logic vec_resp = vec_r & isamp_r & ~chain_grant_in_n;

    // skip: level mode looks at sense, edge mode at the sample
    wire logic skip_cond = cfg_r.edge_mode ? fsamp_r : sense_true;
    wire logic skip_pull = wr_act & is_skip & skip_cond;

    // the skip and control-line enables below are gated by wr_act, so none is
    // pulled outside a write pulse inside an access; the request enable is not
    // first control line: clear accumulator or transfer-and-clear
    wire logic clr_ac_ok = (cmd == IOCD_CMD_CLR_AC) & ~cfg_r.io_dir;
    wire logic c0_cmd = addr_hit & cfg_r.c_ctrl & (clr_ac_ok | (cmd == IOCD_CMD_XFER_CLR));
    wire logic c0_pull = wr_act & (c0_cmd | vec_resp);
    // second control line marks an input transfer
    wire logic c1_cmd = addr_hit & cfg_r.c_ctrl & ~cfg_r.io_dir & is_xfer;
    wire logic c1_pull = wr_act & (c1_cmd | vec_resp);

    // a false chain input removes both the request and the chance to sample
    // interrupt condition seen by request and sample; the chain output sees the sample and the chain input
    wire logic int_cond = cfg_r.edge_mode & flag_r & ie_r & ~chain_grant_in_n;

    // flag events; the hardware set beats a clear in the same cycle
    wire logic flag_set = sense_edge | (acc_rise & is_setf & cfg_r.edge_mode);
    wire logic flag_clr_skip = acc_rise & is_skip & fsamp_r & cfg_r.edge_mode;
    wire logic flag_clr_vec = rd_fall & vec_resp;
    wire logic strobe_set = acc_rise & addr_hit & is_xfer;
    // a sense edge clears the strobe only in edge mode, set flag always
    wire logic strobe_clr = sense_edge | (acc_rise & is_setf);

    // register port decode
    wire logic cfg_wr = reg_wr & (reg_addr == IOCD_CFG_OFS);
    wire logic [11:0] stat_word = {
        5'h00,
        first_pend_r,
        vec_r,
        strobe_r,
        isamp_r,
        ie_r,
        fsamp_r,
        flag_r
    };
    // unmapped reads return zero
    wire logic [11:0] rd_mux =
        (reg_addr == IOCD_CFG_OFS) ? cfg_r :
        (reg_addr == IOCD_STAT_OFS) ? stat_word : 12'h000;

    // phase leaves idle only on a strobe fall and returns only on its rise;
    // the default branch recovers from an unused code
    // access phase follows the processor strobe
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            IOCD_PH_IDLE: begin
                if (acc_fall) begin
                    phase_nxt = IOCD_PH_ACCESS;
                end
            end
            IOCD_PH_ACCESS: begin
                if (acc_rise) begin
                    phase_nxt = IOCD_PH_IDLE;
                end
            end
            default: begin
                phase_nxt = IOCD_PH_IDLE;
            end
        endcase
    end

    // flag next value; level mode pins it at zero
    always_comb begin
        if (!cfg_r.edge_mode) begin
            flag_nxt = 1'b0;
        end else if (flag_set) begin
            flag_nxt = 1'b1;
        end else if (flag_clr_skip | flag_clr_vec) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r;
        end
    end

    // strobe next value; a transfer in the same cycle wins
    always_comb begin
        if (strobe_set) begin
            strobe_nxt = 1'b1;
        end else if (strobe_clr) begin
            strobe_nxt = 1'b0;
        end else begin
            strobe_nxt = strobe_r;
        end
    end

    // clearing while the enable is low keeps a stale sample from blocking
    // the chain after software turns interrupts off
    // interrupt sample: edge set wins over the skip clear
    always_comb begin
        if (grant_fall & int_cond) begin
            isamp_nxt = 1'b1;
        end else if (!ie_r || (acc_rise & is_skip)) begin
            isamp_nxt = 1'b0;
        end else begin
            isamp_nxt = isamp_r;
        end
    end

    // previous levels of the timing inputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            as_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b1;
            gnt_prev_r <= 1'b1;
            sense_prev_r <= 1'b0;
        end else begin
            as_prev_r <= device_access_strobe_n;
            wr_prev_r <= write_n;
            rd_prev_r <= read_n;
            gnt_prev_r <= interrupt_grant_n;
            sense_prev_r <= sense_true;
        end
    end

    // access phase and the instruction it carries
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_r <= IOCD_PH_IDLE;
            instr_r <= 12'h000;
            vec_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            if (acc_fall) begin
                instr_r <= data_in;
                vec_r <= vector_now;
            end
        end
    end

    // a grant rise cancels a pending decision, so a late access never
    // turns into a vector read
    // first access under grant decides skip versus vector
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_pend_r <= 1'b0;
        end else if (interrupt_grant_n || acc_fall) begin
            first_pend_r <= 1'b0;
        end else if (grant_fall) begin
            first_pend_r <= 1'b1;
        end
    end

    // flag, strobe and interrupt sample flip flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_r <= IOCD_FF_RST;
            strobe_r <= IOCD_FF_RST;
            isamp_r <= IOCD_FF_RST;
        end else begin
            flag_r <= flag_nxt;
            strobe_r <= strobe_nxt;
            isamp_r <= isamp_nxt;
        end
    end

    // an addressed skip taken in level mode loads a zero sample so a later edge-mode skip
    // cannot act on a stale sample
    // flag sample taken at strobe fall of an addressed skip
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fsamp_r <= IOCD_FF_RST;
        end else if (acc_fall & in_hit & (in_cmd == IOCD_CMD_SKIP)) begin
            fsamp_r <= flag_r & cfg_r.edge_mode;
        end
    end

    // interrupt enable loaded at write of the load command
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ie_r <= IOCD_IE_RST;
        end else if (wr_fall & addr_hit & (cmd == IOCD_CMD_LOAD_IE)) begin
            ie_r <= data_in[IOCD_IE_BIT];
        end
    end

    // vector word, held from the strobe fall to the read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_out_r <= 12'h000;
        end else if (acc_fall & vector_now) begin
            data_out_r <= {IOCD_VEC_ZERO, cfg_r.dev_addr};
        end
    end

    // limitation: a new address takes effect at once, even mid access
    // programming word; writing level mode clears the flag, the other device flip flops are left alone
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_r <= IOCD_CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= reg_wdata;
        end
    end

    // zero outside the answer cycle keeps a shared read bus quiet
    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= 12'h000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 12'h000;
        end
    end

    // the _o halves stay low; the _oe halves say when the pin is pulled
    // open-drain lines only ever pull low
    assign skip_o = 1'b0;
    assign skip_oe = skip_pull;
    assign ctrl_line_zero_o = 1'b0;
    assign ctrl_line_zero_oe = c0_pull;
    assign ctrl_line_one_o = 1'b0;
    assign ctrl_line_one_oe = c1_pull;
    assign interrupt_request_line_o = 1'b0;
    // a false chain input also removes the request drive
    assign interrupt_request_line_oe = int_cond;
    assign chain_grant_out_n = isamp_r | chain_grant_in_n;

    // vector drive only while the read pulse is low
    assign data_out = data_out_r;
    assign data_oe = rd_act & vec_resp;

    // strobe pin shows the flip flop in the programmed polarity
    assign strobe_out = strobe_r ? cfg_r.out_pol : ~cfg_r.out_pol;
    // enable follows the address, or transfers only
    assign enable_n = ~(addr_hit & (cfg_r.en_sel | is_xfer));
    assign reg_rdata = reg_rdata_r;
endmodule : iocd_device

// ### design/iocd_pkg.sv
// shared constants and types for one io controller device slice
package iocd_pkg;
    // software register offsets on the plain port
    localparam logic [7:0] IOCD_CFG_OFS = 8'h00;
    localparam logic [7:0] IOCD_STAT_OFS = 8'h04;
    // reset value of the programming word
    localparam logic [11:0] IOCD_CFG_RST = 12'h000;
    // transfer instruction field positions (bit 0 is the msb)
    localparam int IOCD_ADDR_MSB = 3;
    localparam int IOCD_ADDR_LSB = 8;
    localparam int IOCD_CMD_MSB = 9;
    localparam int IOCD_CMD_LSB = 11;
    localparam int IOCD_IE_BIT = 11;
    // vector word: address on the low-order six lines, zeros above
    localparam int IOCD_VEC_MSB = 6;
    localparam int IOCD_VEC_LSB = 11;
    localparam logic [5:0] IOCD_VEC_ZERO = 6'h00;
    // status register bit positions
    localparam int IOCD_ST_FLAG = 0;
    localparam int IOCD_ST_FSAMP = 1;
    localparam int IOCD_ST_IE = 2;
    localparam int IOCD_ST_ISAMP = 3;
    localparam int IOCD_ST_STROBE = 4;
    localparam int IOCD_ST_VEC = 5;
    localparam int IOCD_ST_FIRST = 6;
    // reset values of the device flip flops
    localparam logic IOCD_IE_RST = 1'b1;
    localparam logic IOCD_FF_RST = 1'b0;

    // command field of a transfer instruction
    typedef enum logic [2:0] {
        IOCD_CMD_SET_FLAG = 3'b000,
        IOCD_CMD_SKIP = 3'b001,
        IOCD_CMD_CLR_AC = 3'b010,
        IOCD_CMD_NOP_A = 3'b011,
        IOCD_CMD_XFER = 3'b100,
        IOCD_CMD_LOAD_IE = 3'b101,
        IOCD_CMD_XFER_CLR = 3'b110,
        IOCD_CMD_NOP_B = 3'b111
    } iocd_cmd_e;

    // access phase of the processor strobe
    typedef enum logic [1:0] {
        IOCD_PH_IDLE = 2'b00,
        IOCD_PH_ACCESS = 2'b01
    } iocd_phase_e;

    // programming word, msb first
    typedef struct packed {
        logic io_dir;      // 1 output port, 0 input port
        logic c_ctrl;      // transfers steer the control lines
        logic en_sel;      // enable on any addressed access
        logic edge_mode;   // 1 edge sensitive sense, 0 level
        logic in_pol;      // 1 high true sense
        logic out_pol;     // 1 high true strobe
        logic [5:0] dev_addr;
    } iocd_cfg_s;
endpackage : iocd_pkg

// ### verification/iocd_cpu_model.sv
`timescale 1ns/100ps
// processor side: issues transfer instructions and watches the answer lines
module iocd_cpu_model (
    input wire logic core_clk,
    input wire logic [0:11] dev_data,
    input wire logic dev_oe,
    input wire logic skip_oe,
    input wire logic c0_oe,
    input wire logic c1_oe,
    output logic strobe_n,
    output logic write_n,
    output logic read_n,
    output logic [0:11] bus
);
    logic [0:11] cpu_data; // processor's own drive
    logic [2:0] seen; // skip, first, second line pulled in write
    logic [0:11] rd_word; // bus word taken in read
    // device wins the bus only while it drives
    assign bus = dev_oe ? dev_data : cpu_data;
    initial begin
        strobe_n = 1'b1;
        write_n = 1'b1;
        read_n = 1'b1;
        cpu_data = 12'h000;
    end
    // one transfer: strobe, write, gap, read, release, trailing gap
    task automatic io_transfer_instruction(input logic [0:11] instr, input logic [0:11] ac);
        @(posedge core_clk);
        strobe_n <= 1'b0;
        cpu_data <= instr;
        repeat (3) @(posedge core_clk);
        write_n <= 1'b0;
        cpu_data <= ac;
        @(posedge core_clk);
        #1 seen = {skip_oe, c0_oe, c1_oe};
        @(posedge core_clk);
        write_n <= 1'b1;
        @(posedge core_clk);
        read_n <= 1'b0;
        cpu_data <= ~ac; // released bus must not keep the last word
        @(posedge core_clk);
        #1 rd_word = bus;
        @(posedge core_clk);
        read_n <= 1'b1;
        @(posedge core_clk);
        strobe_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : io_transfer_instruction
endmodule : iocd_cpu_model

// ### verification/iocd_device_props.sv
`timescale 1ns/100ps
// port level checker for one device slice
module iocd_device_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic device_access_strobe_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic [0:11] data_out,
    input wire logic data_oe,
    input wire logic interrupt_grant_n,
    input wire logic chain_grant_in_n,
    input wire logic chain_grant_out_n,
    input wire logic interrupt_request_line_o,
    input wire logic interrupt_request_line_oe,
    input wire logic skip_oe,
    input wire logic ctrl_line_zero_oe,
    input wire logic ctrl_line_one_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // request only with the chain input true
    irq_chain_a: assert property (interrupt_request_line_oe |-> !chain_grant_in_n)
        else $error("request pulled with chain input false");
    // grant fall with a live request must latch the sample, seen as a high chain output
    grant_sample_a: assert property ($fell(interrupt_grant_n) && interrupt_request_line_oe
        |-> ##[1:3] chain_grant_out_n)
        else $error("grant fall did not block the chain");
    chain_out_a: assert property (chain_grant_in_n |-> chain_grant_out_n)
        else $error("chain output true with input false");
    skip_write_a: assert property (skip_oe |-> !write_n && !device_access_strobe_n)
        else $error("skip pulled outside a write pulse");
    zero_write_a: assert property (ctrl_line_zero_oe |-> !write_n)
        else $error("first control line pulled outside write");
    one_write_a: assert property (ctrl_line_one_oe |-> !write_n)
        else $error("second control line pulled outside write");
    vec_read_a: assert property (data_oe |-> !read_n && data_out[0:5] == 6'h00)
        else $error("vector word driven badly");
    od_low_a: assert property (interrupt_request_line_oe |-> !interrupt_request_line_o)
        else $error("request line driven high");
endmodule : iocd_device_props

bind iocd_device iocd_device_props iocd_device_props_inst (.core_clk, .rst_n,
    .device_access_strobe_n, .write_n, .read_n, .data_out, .data_oe, .interrupt_grant_n,
    .chain_grant_in_n, .chain_grant_out_n, .interrupt_request_line_o,
    .interrupt_request_line_oe, .skip_oe, .ctrl_line_zero_oe, .ctrl_line_one_oe);

// ### verification/iocd_device_test.sv
`timescale 1ns/100ps
// bench for one device slice behind a processor model
module iocd_device_test;
    import iocd_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd, sense_in, interrupt_grant_n, chain_grant_in_n;
    logic [7:0] reg_addr;
    logic [11:0] reg_wdata, reg_rdata;
    logic device_access_strobe_n, write_n, read_n, data_oe, chain_grant_out_n, strobe_out;
    logic [0:11] data_in, data_out;
    logic interrupt_request_line_o, interrupt_request_line_oe, skip_o, skip_oe, enable_n;
    logic ctrl_line_zero_o, ctrl_line_zero_oe, ctrl_line_one_o, ctrl_line_one_oe;
    int bad_count;
    int checks_done;
    localparam logic [5:0] ADR = 6'h12; // slice address used throughout
    iocd_device iocd_device_inst (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .device_access_strobe_n, .write_n, .read_n, .data_in, .data_out, .data_oe,
        .interrupt_grant_n, .chain_grant_in_n, .chain_grant_out_n, .interrupt_request_line_o,
        .interrupt_request_line_oe, .skip_o, .skip_oe, .ctrl_line_zero_o, .ctrl_line_zero_oe,
        .ctrl_line_one_o, .ctrl_line_one_oe, .sense_in, .strobe_out, .enable_n);
    iocd_cpu_model iocd_cpu_model_inst (.core_clk, .dev_data(data_out), .dev_oe(data_oe),
        .skip_oe, .c0_oe(ctrl_line_zero_oe), .c1_oe(ctrl_line_one_oe),
        .strobe_n(device_access_strobe_n), .write_n, .read_n, .bus(data_in));
    // one value against its expectation
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [11:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [11:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask : rd
    // status flip flops, flag sample, vector and first-pending bits left out
    task automatic st(input logic [11:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= IOCD_STAT_OFS;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata & 12'h01d, e);
    endtask : st
    // instruction plus the lines pulled during its write
    task automatic io(input logic [5:0] a, input iocd_cmd_e c, input logic [11:0] ac,
        input logic [2:0] e);
        iocd_cpu_model_inst.io_transfer_instruction({3'b110, a, c}, ac);
        cmp(iocd_cpu_model_inst.seen, e);
    endtask : io
    task automatic s_reset;
        rd(IOCD_CFG_OFS, 12'h000);
        st(12'h004);
        rd(8'h08, 12'h000);
        cmp(strobe_out, 1'b1);
        cmp({skip_o, ctrl_line_zero_o, ctrl_line_one_o, interrupt_request_line_o, enable_n},
            5'h01);
    endtask : s_reset
    // level mode, controlled input port, high true polarities
    task automatic s_level;
        wr(IOCD_CFG_OFS, {6'h13, ADR});
        sense_in <= 1'b1;
        io(ADR, IOCD_CMD_SKIP, 0, 3'b100);
        sense_in <= 1'b0;
        io(ADR, IOCD_CMD_SKIP, 0, 3'b000);
        io(ADR, IOCD_CMD_SET_FLAG, 0, 3'b000);
        st(12'h004);
        fork
            io(ADR, IOCD_CMD_XFER, 0, 3'b001);
            begin
                repeat (5) @(posedge core_clk);
                #1 cmp(enable_n, 1'b0);
            end
        join
        cmp(enable_n, 1'b1);
        cmp(strobe_out, 1'b1);
        io(ADR, IOCD_CMD_XFER_CLR, 0, 3'b011);
        io(ADR, IOCD_CMD_CLR_AC, 0, 3'b010);
        io(ADR, IOCD_CMD_NOP_A, 0, 3'b000);
        io(ADR, IOCD_CMD_NOP_B, 0, 3'b000);
        io(6'h13, IOCD_CMD_SET_FLAG, 0, 3'b000);
        st(12'h014);
        io(ADR, IOCD_CMD_SET_FLAG, 0, 3'b000);
        cmp(strobe_out, 1'b0);
    endtask : s_level
    // edge mode, uncontrolled output port
    task automatic s_edge;
        wr(IOCD_CFG_OFS, {6'h27, ADR});
        io(ADR, IOCD_CMD_LOAD_IE, 12'h000, 3'b000);
        io(ADR, IOCD_CMD_XFER_CLR, 0, 3'b000);
        io(ADR, IOCD_CMD_CLR_AC, 0, 3'b000);
        cmp(strobe_out, 1'b1);
        sense_in <= 1'b1;
        st(12'h001);
        cmp(interrupt_request_line_oe, 1'b0);
        io(ADR, IOCD_CMD_SKIP, 0, 3'b100);
        st(12'h000);
        io(ADR, IOCD_CMD_SKIP, 0, 3'b000);
        io(ADR, IOCD_CMD_SET_FLAG, 0, 3'b000);
        io(ADR, IOCD_CMD_LOAD_IE, 12'h001, 3'b000);
        st(12'h005);
        cmp(interrupt_request_line_oe, 1'b1);
    endtask : s_edge
    // grant, vector read, skip release, chain blocked from above
    task automatic s_intr;
        interrupt_grant_n <= 1'b0;
        st(12'h00d);
        cmp(chain_grant_out_n, 1'b1);
        io(6'h2a, IOCD_CMD_XFER, 0, 3'b011);
        cmp(iocd_cpu_model_inst.rd_word, {6'h00, ADR});
        st(12'h00c);
        io(ADR, IOCD_CMD_SKIP, 0, 3'b000);
        st(12'h004);
        interrupt_grant_n <= 1'b1;
        cmp(chain_grant_out_n, 1'b0);
        io(ADR, IOCD_CMD_SET_FLAG, 0, 3'b000);
        chain_grant_in_n <= 1'b1;
        @(posedge core_clk);
        #1 cmp({interrupt_request_line_oe, chain_grant_out_n}, 2'b01);
    endtask : s_intr
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard well past the expected run length
    initial begin
        repeat (8000) @(posedge core_clk);
        bad_count++;
        complete_run;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, sense_in, chain_grant_in_n} = 5'b0;
        interrupt_grant_n = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 12'h000;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        s_reset;
        s_level;
        s_edge;
        s_intr;
        complete_run;
    end
endmodule : iocd_device_test
